// *** common/mct_defines.svh ***
// register offsets, field positions and reset values of the counter/timer
`ifndef MCT_DEFINES_SVH
`define MCT_DEFINES_SVH

// register offsets
`define MCT_OFF_CTRL 8'h00
`define MCT_OFF_COUNT 8'h04
`define MCT_OFF_PRELIM 8'h08
`define MCT_OFF_PRECNT 8'h0C
`define MCT_OFF_MCFG 8'h10
`define MCT_OFF_OUTCFG 8'h14
`define MCT_OFF_CAPTURE 8'h18
`define MCT_OFF_IRQEN 8'h1C
`define MCT_OFF_MATCH0 8'h20
`define MCT_MATCH_MASK 8'hF3
`define MCT_OFF_STATUS 8'h30
`define MCT_OFF_CLEAR 8'h34

// field layout
`define MCT_NUM_MATCH 4
`define MCT_CTRL_W 7
`define MCT_MCFG_STOP 0
`define MCT_MCFG_RST 1

// reset values: disabled, timer mode, capture edge off
`define MCT_RST_CTRL 7'h60

`endif

// *** common/mct_pkg.sv ***
// shared types of the match/capture counter/timer
`default_nettype none

package mct_pkg;

  // count source
  typedef enum logic {MODE_TIMER, MODE_COUNTER} mode_t;

  // input edge selection for count and capture
  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_NONE} edge_t;

  // match output action
  typedef enum logic [1:0] {ACT_NONE, ACT_LOW, ACT_HIGH, ACT_TOGGLE} act_t;

  // control register layout, run in bit 0
  typedef struct packed {
    edge_t capEdge;
    edge_t cntEdge;
    mode_t mode;
    logic hold;
    logic run;
  } ctrl_t;

endpackage

`default_nettype wire

// *** rtl/match_capture_counter_timer.sv ***
// counter/timer with prescaler, four matches, capture and interrupt
`timescale 1ns/10ps
`default_nettype none
`include "mct_defines.svh"

module match_capture_counter_timer #(
  parameter int unsigned W = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // external pins
  input wire logic countIn,
  input wire logic captureIn,
  output logic [`MCT_NUM_MATCH-1:0] matchOut,
  // interrupt
  output logic irq
);

  localparam int unsigned NM = `MCT_NUM_MATCH;

  // complete module state, width follows the instance
  typedef struct packed {
    mct_pkg::ctrl_t ctrl;
    logic [W-1:0] count;
    logic [W-1:0] pre;
    logic [W-1:0] preLim;
    logic [NM-1:0][W-1:0] match;
    logic [2*NM-1:0] mcfg;
    logic [2*NM-1:0] ext;
    logic [NM-1:0] pins;
    logic [W-1:0] cap;
    logic [NM:0] status;
    logic [NM:0] irqEn;
    logic [31:0] rdata;
    logic cntPrev;
    logic capPrev;
  } state_t;

  state_t state_q;
  state_t state_d;

  logic timerMode;
  logic active;
  logic preWrap;
  logic cntEdge;
  logic capEdge;
  logic tick;
  logic anyStop;
  logic anyRst;
  logic clearWr;
  logic [W-1:0] cntNext;
  logic [NM-1:0] hit;
  logic [NM:0] events;

  // edge detector shared by count and capture inputs
  function automatic logic edgeSeen(mct_pkg::edge_t sel, logic prev,
                                    logic cur);
    case (sel)
      mct_pkg::EDGE_RISE: edgeSeen = cur & ~prev;
      mct_pkg::EDGE_FALL: edgeSeen = prev & ~cur;
      mct_pkg::EDGE_BOTH: edgeSeen = cur ^ prev;
      default: edgeSeen = 1'b0;
    endcase
  endfunction

  // one bit of each match's two-bit config field
  function automatic logic [NM-1:0] pick(logic [2*NM-1:0] v,
                                         int unsigned off);
    for (int i = 0; i < NM; i++) begin
      pick[i] = v[2*i+off];
    end
  endfunction

  // the four match registers sit on one aligned block
  function automatic logic isMatch(logic [7:0] addr);
    isMatch = (addr & `MCT_MATCH_MASK) == `MCT_OFF_MATCH0;
  endfunction

  // count source: prescaled clock or external edges
  assign timerMode = state_q.ctrl.mode == mct_pkg::MODE_TIMER;
  assign active = state_q.ctrl.run & ~state_q.ctrl.hold;
  assign preWrap = active & timerMode &
                   (state_q.pre == state_q.preLim);
  assign cntEdge = edgeSeen(state_q.ctrl.cntEdge, state_q.cntPrev,
                            countIn);
  assign tick = timerMode ? preWrap : (active & cntEdge);
  assign cntNext = state_q.count + 1'b1;
  assign capEdge = edgeSeen(state_q.ctrl.capEdge, state_q.capPrev,
                            captureIn);

  // matches only count on a tick, so a held count fires once
  always_comb begin
    for (int i = 0; i < NM; i++) begin
      hit[i] = tick & (state_q.count == state_q.match[i]);
    end
  end

  // any matching register asking for stop or reset
  assign anyStop = |(hit & pick(state_q.mcfg, `MCT_MCFG_STOP));
  assign anyRst = |(hit & pick(state_q.mcfg, `MCT_MCFG_RST));
  assign events = {capEdge, hit};
  assign clearWr = regWr & (regAddr == `MCT_OFF_CLEAR);

  // next state: counting first, software writes last so they win, except a clear beside a new event
  always_comb begin
    state_d = state_q;
    state_d.cntPrev = countIn;
    state_d.capPrev = captureIn;

    // prescaler, held at zero with the count while hold is set
    if (state_q.ctrl.hold) begin
      state_d.pre = '0;
      state_d.count = '0;
    end else if (active & timerMode) begin
      state_d.pre = preWrap ? '0 : state_q.pre + 1'b1;
    end

    // count advance and match actions on the count
    if (tick) begin
      if (anyRst) begin
        state_d.count = '0;
      end else begin
        state_d.count = cntNext;
      end
      if (anyStop) begin
        state_d.ctrl.run = 1'b0;
      end
    end

    // match output pins
    for (int i = 0; i < NM; i++) begin
      if (hit[i]) begin
        case (mct_pkg::act_t'(state_q.ext[2*i +: 2]))
          mct_pkg::ACT_LOW: state_d.pins[i] = 1'b0;
          mct_pkg::ACT_HIGH: state_d.pins[i] = 1'b1;
          mct_pkg::ACT_TOGGLE: state_d.pins[i] = ~state_q.pins[i];
          default: state_d.pins[i] = state_q.pins[i];
        endcase
      end
    end

    // capture snapshot of the count before this edge's update
    if (capEdge) begin
      state_d.cap = state_q.count;
    end

    // sticky flags: a new event beats a clear in the same cycle
    state_d.status = (state_q.status & ~(clearWr ? regWdata[NM:0] : '0))
                     | events;

    // register writes
    if (regWr && isMatch(regAddr)) begin
      state_d.match[regAddr[3:2]] = regWdata[W-1:0];
    end
    if (regWr) begin
      case (regAddr)
        `MCT_OFF_CTRL: begin
          state_d.ctrl = mct_pkg::ctrl_t'(regWdata[`MCT_CTRL_W-1:0]);
        end
        `MCT_OFF_COUNT: state_d.count = regWdata[W-1:0];
        `MCT_OFF_PRELIM: state_d.preLim = regWdata[W-1:0];
        `MCT_OFF_PRECNT: state_d.pre = regWdata[W-1:0];
        `MCT_OFF_MCFG: state_d.mcfg = regWdata[2*NM-1:0];
        `MCT_OFF_OUTCFG: begin
          state_d.ext = regWdata[2*NM-1:0];
          state_d.pins = regWdata[3*NM-1:2*NM];
        end
        `MCT_OFF_IRQEN: state_d.irqEn = regWdata[NM:0];
        default: state_d.irqEn = state_d.irqEn;
      endcase
    end

    // read data, valid only in the cycle after the read strobe
    state_d.rdata = '0;
    if (regRd) begin
      if (isMatch(regAddr)) begin
        state_d.rdata = 32'(state_q.match[regAddr[3:2]]);
      end else begin
        case (regAddr)
          `MCT_OFF_CTRL: state_d.rdata = 32'(state_q.ctrl);
          `MCT_OFF_COUNT: state_d.rdata = 32'(state_q.count);
          `MCT_OFF_PRELIM: state_d.rdata = 32'(state_q.preLim);
          `MCT_OFF_PRECNT: state_d.rdata = 32'(state_q.pre);
          `MCT_OFF_MCFG: state_d.rdata = 32'(state_q.mcfg);
          `MCT_OFF_OUTCFG: state_d.rdata = 32'({state_q.pins, state_q.ext});
          `MCT_OFF_CAPTURE: state_d.rdata = 32'(state_q.cap);
          `MCT_OFF_IRQEN: state_d.rdata = 32'(state_q.irqEn);
          `MCT_OFF_STATUS: state_d.rdata = 32'(state_q.status);
          default: state_d.rdata = '0;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= '0;
      state_q.ctrl <= mct_pkg::ctrl_t'(`MCT_RST_CTRL);
    end else begin
      state_q <= state_d;
    end
  end

  // outputs; irq is a gate of flops so it drops with the clear
  assign regRdata = state_q.rdata;
  assign matchOut = state_q.pins;
  assign irq = |(state_q.status & state_q.irqEn);

  // prescaler restarts from zero after its limit
  preWrap_a: assert property (@(posedge core_clk) disable iff (reset)
    preWrap && !regWr |=> state_q.pre == '0)
    else $error("prescaler did not restart at its limit");

  // timer count advances on each prescaler wrap
  timerTick_a: assert property (@(posedge core_clk) disable iff (reset)
    preWrap && !anyRst && !regWr |=> state_q.count == $past(cntNext))
    else $error("timer count did not advance on prescaler wrap");

  // counter mode holds the count between input edges
  counterHold_a: assert property (@(posedge core_clk)
    disable iff (reset)
    !timerMode && !cntEdge && !regWr && !state_q.ctrl.hold
    |=> $stable(state_q.count))
    else $error("count moved without an input edge");

  // continuous match keeps running and counting
  matchRun_a: assert property (@(posedge core_clk) disable iff (reset)
    (|hit) && !anyStop && !anyRst && !regWr
    |=> state_q.ctrl.run && state_q.count == $past(cntNext))
    else $error("continuous match disturbed the count");

  // stop match halts the counter and keeps the count
  matchStop_a: assert property (@(posedge core_clk) disable iff (reset)
    tick && anyStop && !regWr ##1 !regWr
    |=> !state_q.ctrl.run && $stable(state_q.count))
    else $error("stop match did not halt the count");

  // reset match returns the count to zero
  matchReset_a: assert property (@(posedge core_clk)
    disable iff (reset)
    tick && anyRst && !regWr |=> state_q.count == '0)
    else $error("reset match did not zero the count");

  // toggle action inverts the first output
  pinToggle_a: assert property (@(posedge core_clk) disable iff (reset)
    hit[0] && state_q.ext[1:0] == mct_pkg::ACT_TOGGLE && !regWr
    |=> matchOut[0] != $past(matchOut[0]))
    else $error("toggle match did not invert the output");

  // match sets its flag
  matchFlag_a: assert property (@(posedge core_clk) disable iff (reset)
    hit[0] |=> state_q.status[0])
    else $error("match did not set its flag");

  // capture holds the count seen at the edge
  captureValue_a: assert property (@(posedge core_clk)
    disable iff (reset)
    capEdge |=> state_q.cap == $past(state_q.count))
    else $error("capture missed the count value");

  // enabled capture event raises the interrupt
  captureIrq_a: assert property (@(posedge core_clk)
    disable iff (reset)
    capEdge && state_q.irqEn[NM] && !regWr |=> irq)
    else $error("enabled capture gave no interrupt");

  // flags only fall by a clear write
  flagSticky_a: assert property (@(posedge core_clk)
    disable iff (reset)
    !clearWr |=> (state_q.status & $past(state_q.status))
                 == $past(state_q.status))
    else $error("flag dropped without a clear");

  // every event leaves its flag set, even beside a clear
  flagSet_a: assert property (@(posedge core_clk)
    disable iff (reset)
    |events |=> (state_q.status & $past(events)) == $past(events))
    else $error("event did not set its flag");

  // a clear with no event empties the chosen flags
  flagClear_a: assert property (@(posedge core_clk)
    disable iff (reset)
    clearWr && !(|events)
    |=> (state_q.status & $past(regWdata[NM:0])) == '0)
    else $error("clear write left a flag set");

  // hold forces count and prescaler to zero
  holdZero_a: assert property (@(posedge core_clk)
    disable iff (reset)
    state_q.ctrl.hold && !regWr
    |=> state_q.count == '0 && state_q.pre == '0)
    else $error("hold did not clear count and prescaler");

  // prescaler steps by one below its limit
  preStep_a: assert property (@(posedge core_clk)
    disable iff (reset)
    active && timerMode && !preWrap && !regWr
    |=> state_q.pre == $past(state_q.pre) + 1'b1)
    else $error("prescaler did not step by one");

  // a stopped prescaler stays where it halted
  preHalt_a: assert property (@(posedge core_clk)
    disable iff (reset)
    !state_q.ctrl.run && !state_q.ctrl.hold && !regWr
    |=> $stable(state_q.pre))
    else $error("prescaler moved while stopped");

  // the count only moves on a tick, a hold or a write
  countStill_a: assert property (@(posedge core_clk)
    disable iff (reset)
    !tick && !state_q.ctrl.hold && !regWr |=> $stable(state_q.count))
    else $error("count moved without a tick");

  // counter mode adds one per selected input edge
  counterStep_a: assert property (@(posedge core_clk)
    disable iff (reset)
    !timerMode && active && cntEdge && !anyRst && !regWr
    |=> state_q.count == $past(cntNext))
    else $error("input edge did not advance the count");

  // reset match keeps the counter running
  rstRun_a: assert property (@(posedge core_clk)
    disable iff (reset)
    tick && anyRst && !anyStop && !regWr |=> state_q.ctrl.run)
    else $error("reset match stopped the counter");

  // high action drives the second output high
  pinHigh_a: assert property (@(posedge core_clk)
    disable iff (reset)
    hit[1] && state_q.ext[3:2] == mct_pkg::ACT_HIGH && !regWr
    |=> matchOut[1])
    else $error("high match did not raise the output");

  // low action drives the third output low
  pinLow_a: assert property (@(posedge core_clk)
    disable iff (reset)
    hit[2] && state_q.ext[5:4] == mct_pkg::ACT_LOW && !regWr
    |=> !matchOut[2])
    else $error("low match did not lower the output");

  // no action leaves the fourth output alone
  pinKeep_a: assert property (@(posedge core_clk)
    disable iff (reset)
    hit[3] && state_q.ext[7:6] == mct_pkg::ACT_NONE && !regWr
    |=> $stable(matchOut[3]))
    else $error("idle match changed the output");

  // outputs move only on a match or a write
  pinsQuiet_a: assert property (@(posedge core_clk)
    disable iff (reset)
    !(|hit) && !regWr |=> $stable(matchOut))
    else $error("output changed without a match");

  // the capture holder keeps its value between edges
  captureKeep_a: assert property (@(posedge core_clk)
    disable iff (reset)
    !capEdge |=> $stable(state_q.cap))
    else $error("capture value changed without an edge");

endmodule // match_capture_counter_timer

`default_nettype wire

// *** tb/mct_pin_partner.sv ***
// pin-side model driving count and capture inputs of the timer
`timescale 1ns/10ps
`default_nettype none

module mct_pin_partner (
  // clock
  input wire logic core_clk,
  // pins toward the timer
  output logic countIn,
  output logic captureIn,
  input wire logic [3:0] matchOut
);
  // both pins idle low between commanded edges
  initial begin
    countIn = 1'b0;
    captureIn = 1'b0;
  end

  // two cycles high and three low between pulses so every edge is sampled
  task automatic countEdges(input int n);
    repeat (n) begin
      @(posedge core_clk) countIn <= 1'b1;
      repeat (2) @(posedge core_clk);
      countIn <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask

  // one rising edge on the capture pin
  task automatic captureEdge;
    @(posedge core_clk) captureIn <= 1'b1;
    repeat (2) @(posedge core_clk);
    captureIn <= 1'b0;
  endtask
endmodule // mct_pin_partner

`default_nettype wire

// *** tb/test_match_capture_counter_timer.sv ***
// self-checking bench of the match/capture counter/timer
`timescale 1ns/10ps
`default_nettype none
`include "mct_defines.svh"

module test_match_capture_counter_timer;
  logic core_clk, reset, regWr, regRd, countIn, captureIn, irq;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, rd;
  logic [3:0] matchOut;
  int fail_count = 0;
  int comparisons = 0;
  // address, written value, value read back
  logic [71:0] rows [8] = '{
    {`MCT_OFF_COUNT, 32'h1234_5678, 32'h1234_5678},
    {`MCT_OFF_PRELIM, 32'h0000_0007, 32'h0000_0007},
    {8'h2C, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
    {`MCT_OFF_MCFG, 32'h0000_00FF, 32'h0000_00FF},
    {`MCT_OFF_MCFG, 32'h0000_0000, 32'h0000_0000},
    {`MCT_OFF_IRQEN, 32'h0000_003F, 32'h0000_001F},
    {`MCT_OFF_CAPTURE, 32'h0000_0055, 32'h0000_0000},
    {8'h40, 32'hFFFF_FFFF, 32'h0000_0000}};

  match_capture_counter_timer #(.W(32)) match_capture_counter_timer_inst (
    .core_clk(core_clk), .reset(reset), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .countIn(countIn), .captureIn(captureIn),
    .matchOut(matchOut), .irq(irq));
  mct_pin_partner mct_pin_partner_inst (.core_clk(core_clk),
    .countIn(countIn), .captureIn(captureIn), .matchOut(matchOut));

  // 50 ns clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    rd = regRdata;
    check($sformatf("reg %h", a), rd, e);
  endtask

  task automatic conclude;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // bounded wait; running out counts against the run
  // sampled on the falling edge, where irq has settled
  task automatic waitIrq;
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(negedge core_clk);
    if (irq !== 1'b1) begin
      fail_count++;
      conclude();
    end
  endtask

  initial begin
    reset = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    check("irq", irq, 32'h0000_0000);
    check("pins", matchOut, 32'h0000_0000);
    rdChk(`MCT_OFF_CTRL, 32'h0000_0060);
    foreach (rows[i]) begin
      wr(rows[i][71:64], rows[i][63:32]);
      rdChk(rows[i][71:64], rows[i][31:0]);
    end
    // prescale limit 4: one count every 5 clocks
    wr(`MCT_OFF_COUNT, 32'h0000_0000);
    wr(`MCT_OFF_PRELIM, 32'h0000_0004);
    wr(`MCT_OFF_CTRL, 32'h0000_0001);
    repeat (20) @(posedge core_clk);
    wr(`MCT_OFF_CTRL, 32'h0000_0060);
    rdChk(`MCT_OFF_COUNT, 32'h0000_0004);
    // continuous match 0, stop on match 1, all four pin actions
    wr(`MCT_OFF_CLEAR, 32'h0000_001F);
    wr(`MCT_OFF_COUNT, 32'h0000_0000);
    wr(`MCT_OFF_PRELIM, 32'h0000_0000);
    wr(`MCT_OFF_PRECNT, 32'h0000_0000);
    wr(`MCT_OFF_MATCH0, 32'h0000_0002);
    for (int m = 1; m < 4; m++) wr(8'h20 + 8'(4 * m), 32'h0000_0005);
    wr(`MCT_OFF_MCFG, 32'h0000_0004);
    wr(`MCT_OFF_OUTCFG, 32'h0000_0C1B);
    wr(`MCT_OFF_IRQEN, 32'h0000_0000);
    wr(`MCT_OFF_CTRL, 32'h0000_0001);
    repeat (20) @(posedge core_clk);
    rdChk(`MCT_OFF_COUNT, 32'h0000_0006);
    // the stop match clears the run bit of the 0x01 written
    rdChk(`MCT_OFF_CTRL, 32'h0000_0000);
    check("pins", matchOut, 32'h0000_000B);
    rdChk(`MCT_OFF_STATUS, 32'h0000_000F);
    check("irq", irq, 32'h0000_0000);
    // reset on match 0: count wraps below 4
    wr(`MCT_OFF_CLEAR, 32'h0000_001F);
    wr(`MCT_OFF_MCFG, 32'h0000_0002);
    wr(`MCT_OFF_MATCH0, 32'h0000_0003);
    wr(`MCT_OFF_COUNT, 32'h0000_0000);
    wr(`MCT_OFF_IRQEN, 32'h0000_0001);
    wr(`MCT_OFF_CTRL, 32'h0000_0001);
    waitIrq();
    repeat (30) @(posedge core_clk);
    wr(`MCT_OFF_CTRL, 32'h0000_0060);
    // 36 single-clock ticks from run to stop, wrapping every 4
    rdChk(`MCT_OFF_COUNT, 32'h0000_0000);
    check("wrap", rd <= 32'h0000_0003, 32'h0000_0001);
    wr(`MCT_OFF_IRQEN, 32'h0000_0000);
    @(negedge core_clk);
    check("masked", irq, 32'h0000_0000);
    wr(`MCT_OFF_IRQEN, 32'h0000_0001);
    @(negedge core_clk);
    check("unmasked", irq, 32'h0000_0001);
    wr(`MCT_OFF_CLEAR, 32'h0000_001F);
    @(negedge core_clk);
    check("cleared", irq, 32'h0000_0000);
    rdChk(`MCT_OFF_STATUS, 32'h0000_0000);
    // counter mode: four input edges, then a capture
    wr(`MCT_OFF_MCFG, 32'h0000_0000);
    wr(`MCT_OFF_COUNT, 32'h0000_0000);
    wr(`MCT_OFF_IRQEN, 32'h0000_0010);
    wr(`MCT_OFF_CTRL, 32'h0000_0005);
    mct_pin_partner_inst.countEdges(4);
    mct_pin_partner_inst.captureEdge();
    repeat (2) @(posedge core_clk);
    rdChk(`MCT_OFF_CAPTURE, 32'h0000_0004);
    // match 0 at count 3 flags as well, without an interrupt
    rdChk(`MCT_OFF_STATUS, 32'h0000_0011);
    check("capture irq", irq, 32'h0000_0001);
    // hold zeroes a loaded count and prescaler
    wr(`MCT_OFF_COUNT, 32'h0000_0009);
    wr(`MCT_OFF_PRECNT, 32'h0000_0005);
    wr(`MCT_OFF_CTRL, 32'h0000_0003);
    rdChk(`MCT_OFF_COUNT, 32'h0000_0000);
    rdChk(`MCT_OFF_PRECNT, 32'h0000_0000);
    // reset in mid-run brings back the defaults
    wr(`MCT_OFF_CTRL, 32'h0000_0001);
    repeat (3) @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    check("irq", irq, 32'h0000_0000);
    check("pins", matchOut, 32'h0000_0000);
    rdChk(`MCT_OFF_CTRL, 32'h0000_0060);
    rdChk(`MCT_OFF_STATUS, 32'h0000_0000);
    conclude();
  end
endmodule // test_match_capture_counter_timer

`default_nettype wire
